//--- bus_state_source.sv
// Model of the emulated processor bus that feeds sampled bus states
module bus_state_source (
	input  wire logic        clk_i,
	output logic             smp_valid_o,
	output logic      [31:0] smp_data_o,
	output logic             smp_bg_o,
	output logic      [7:0]  pat_hit_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		smp_valid_o = 1'b0;
		smp_data_o  = 32'h0000_0000;
		smp_bg_o    = 1'b0;
		pat_hit_o   = 8'h00;
	end

	// One state every second bus clock; idle lines show the inverse of the last value
	task automatic send(input logic [31:0] d, input logic bg,
			input logic [7:0] h);
		@(posedge clk_i);
		smp_valid_o <= 1'b1;
		smp_data_o  <= d;
		smp_bg_o    <= bg;
		pat_hit_o   <= h;
		@(posedge clk_i);
		smp_valid_o <= 1'b0;
		smp_data_o  <= ~d;
		smp_bg_o    <= ~bg;
		pat_hit_o   <= ~h;
	endtask
endmodule

//--- bus_trace_capture_qualifier.sv
// Trace capture qualifier: sequencer, store, prestore and count logic
//
// The plain strobed port and the register addresses were decided locally.
module bus_trace_capture_qualifier (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	input  wire logic [6:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic        smp_valid_i,
	input  wire logic [31:0] smp_data_i,
	input  wire logic        smp_bg_i,
	input  wire logic [7:0]  pat_hit_i,
	output logic      [4:0]  ana_clk_en_o,
	output logic             wait_insert_o,
	output logic             store_o,
	output logic      [31:0] store_data_o,
	output logic      [2:0]  store_term_o,
	output logic             store_seq_adv_o,
	output logic      [31:0] store_count_o,
	output logic             pre_o,
	output logic      [31:0] pre_data_o,
	output logic             trig_o
);
	typedef enum logic {ST_IDLE, ST_RUN} run_state_t;

	run_state_t  state_q, state_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [8:0]  preq_q, preq_d;
	logic [8:0]  cntq_q, cntq_d;
	logic [7:0]  busclk_q, busclk_d;
	logic [31:0] term_a_q [trace_qual_pkg::N_TERMS];
	logic [31:0] term_a_d [trace_qual_pkg::N_TERMS];
	logic [31:0] term_b_q [trace_qual_pkg::N_TERMS];
	logic [31:0] term_b_d [trace_qual_pkg::N_TERMS];
	logic [31:0] rdata_q, rdata_d;

	logic [2:0]  term_q, term_d;
	logic        trig_seen_q, trig_seen_d;
	logic [31:0] rel_cnt_q, rel_cnt_d;
	logic [31:0] abs_cnt_q, abs_cnt_d;
	logic        pre_vld_q, pre_vld_d;
	logic [31:0] pre_buf_q, pre_buf_d;
	logic        store_q, store_d;
	logic [31:0] sdata_q, sdata_d;
	logic [2:0]  sterm_q, sterm_d;
	logic        sadv_q, sadv_d;
	logic [31:0] scnt_q, scnt_d;
	logic        pre_q, pre_d;
	logic [31:0] pdata_q, pdata_d;
	logic        trig_q, trig_d;

	logic        start_w, stop_w, running, ctx_ok, take, store_now;
	logic [1:0]  rate_cls, cmode_eff, rate_sugg;
	logic [7:0]  eff_mhz;
	logic        wait_ins, cnt_inc;
	logic [31:0] status_w;

	seq_if sq ();
	seq_step u_step (
		.s (sq)
	);

	function automatic logic term_area(input logic [6:0] a);
		return (a >= trace_qual_pkg::REG_TERM0) &&
			(a < trace_qual_pkg::REG_TERM_END) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [2:0] term_index(input logic [6:0] a);
		logic [6:0] off;
		off = 7'(a - trace_qual_pkg::REG_TERM0);
		return off[5:3];
	endfunction

	// Configuration fields
	assign running  = (state_q == ST_RUN);
	assign rate_cls = ctrl_q[trace_qual_pkg::CTL_RATE +: 2];
	assign ctx_ok   = smp_bg_i ? ctrl_q[trace_qual_pkg::CTL_CTX + 1]
		: ctrl_q[trace_qual_pkg::CTL_CTX]; // RULE4
	assign cmode_eff = trace_qual_pkg::count_allowed(
		ctrl_q[trace_qual_pkg::CTL_CMODE +: 2], rate_cls); // RULE10
	assign start_w = reg_we_i && (reg_addr_i == trace_qual_pkg::REG_CTRL)
		&& reg_wdata_i[trace_qual_pkg::CTL_START];
	assign stop_w = reg_we_i && (reg_addr_i == trace_qual_pkg::REG_CTRL)
		&& reg_wdata_i[trace_qual_pkg::CTL_STOP];

	// Wait insertion and effective burst sample rate
	assign wait_ins = (busclk_q >= trace_qual_pkg::WAIT_MIN_MHZ); // RULE9
	assign eff_mhz  = wait_ins ? {1'b0, busclk_q[7:1]} : busclk_q; // RULE8
	always_comb begin
		if (eff_mhz <= trace_qual_pkg::SLOW_MAX_MHZ)
			rate_sugg = trace_qual_pkg::RATE_SLOW; // RULE5
		else if (eff_mhz <= trace_qual_pkg::FAST_MAX_MHZ)
			rate_sugg = trace_qual_pkg::RATE_FAST;
		else
			rate_sugg = trace_qual_pkg::RATE_VFAST;
	end

	assign status_w = {21'h0,
		(cmode_eff != ctrl_q[trace_qual_pkg::CTL_CMODE +: 2]),
		(busclk_q <= trace_qual_pkg::CAPTURE_MAX_MHZ), // RULE7
		wait_ins, rate_sugg, pre_vld_q, trig_seen_q, term_q, running};

	// Register file next state and read path
	always_comb begin
		ctrl_d   = ctrl_q;
		preq_d   = preq_q;
		cntq_d   = cntq_q;
		busclk_d = busclk_q;
		term_a_d = term_a_q;
		term_b_d = term_b_q;
		rdata_d  = 32'h0000_0000;
		if (reg_we_i) begin
			case (reg_addr_i)
				trace_qual_pkg::REG_CTRL:
					ctrl_d = reg_wdata_i & trace_qual_pkg::CTRL_WMASK; // RULE2
				trace_qual_pkg::REG_PREQ:   preq_d = reg_wdata_i[8:0];
				trace_qual_pkg::REG_CNTQ:   cntq_d = reg_wdata_i[8:0];
				trace_qual_pkg::REG_BUSCLK: busclk_d = reg_wdata_i[7:0];
				default: begin
					if (term_area(reg_addr_i)) begin
						if (reg_addr_i[2])
							term_b_d[term_index(reg_addr_i)] = reg_wdata_i;
						else
							term_a_d[term_index(reg_addr_i)] = reg_wdata_i;
					end
				end
			endcase
		end
		if (reg_re_i) begin
			case (reg_addr_i)
				trace_qual_pkg::REG_CTRL:   rdata_d = ctrl_q;
				trace_qual_pkg::REG_STATUS: rdata_d = status_w;
				trace_qual_pkg::REG_PREQ:   rdata_d = {23'h0, preq_q};
				trace_qual_pkg::REG_CNTQ:   rdata_d = {23'h0, cntq_q};
				trace_qual_pkg::REG_BUSCLK: rdata_d = {24'h0, busclk_q};
				default: begin
					if (term_area(reg_addr_i))
						rdata_d = reg_addr_i[2] ?
							term_b_q[term_index(reg_addr_i)] :
							term_a_q[term_index(reg_addr_i)];
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q   <= trace_qual_pkg::CTRL_RST; // RULE6
			preq_q   <= trace_qual_pkg::QUAL_NEVER;
			cntq_q   <= trace_qual_pkg::QUAL_NEVER; // RULE14
			busclk_q <= trace_qual_pkg::BUSCLK_RST;
			rdata_q  <= 32'h0000_0000;
			for (int i = 0; i < trace_qual_pkg::N_TERMS; i++) begin
				term_a_q[i] <= trace_qual_pkg::TERMA_RST;
				term_b_q[i] <= trace_qual_pkg::TERMB_RST;
			end
		end else if (ce_i) begin
			ctrl_q   <= ctrl_d;
			preq_q   <= preq_d;
			cntq_q   <= cntq_d;
			busclk_q <= busclk_d;
			rdata_q  <= rdata_d;
			term_a_q <= term_a_d;
			term_b_q <= term_b_d;
		end
	end

	// Sequencer step inputs
	always_comb begin
		sq.hits        = pat_hit_i;
		sq.term        = term_q;
		sq.word_a      = term_a_q[term_q];
		sq.word_b      = term_b_q[term_q];
		sq.word_a0     = term_a_q[0];
		sq.complex_cfg = ctrl_q[trace_qual_pkg::CTL_CPLX];
	end

	assign take = running && smp_valid_i && ctx_ok;
	assign store_now = take && (sq.store_hit ||
		(sq.advance && ctrl_q[trace_qual_pkg::CTL_INC])); // RULE1
	assign cnt_inc = running && ((cmode_eff == trace_qual_pkg::CM_TIME) ||
		((cmode_eff == trace_qual_pkg::CM_STATE) && take &&
		trace_qual_pkg::qual_eval(cntq_q, pat_hit_i))); // RULE12

	// Capture path next state
	always_comb begin
		state_d     = state_q;
		term_d      = term_q;
		trig_seen_d = trig_seen_q;
		rel_cnt_d   = cnt_inc ? 32'(rel_cnt_q + 32'h1) : rel_cnt_q;
		abs_cnt_d   = cnt_inc ? 32'(abs_cnt_q + 32'h1) : abs_cnt_q;
		pre_vld_d   = pre_vld_q;
		pre_buf_d   = pre_buf_q;
		store_d     = 1'b0;
		sdata_d     = sdata_q;
		sterm_d     = sterm_q;
		sadv_d      = 1'b0;
		scnt_d      = scnt_q;
		pre_d       = 1'b0;
		pdata_d     = pdata_q;
		trig_d      = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (start_w) begin
					state_d     = ST_RUN;
					term_d      = reg_wdata_i[trace_qual_pkg::CTL_INIT +: 3]; // RULE3
					trig_seen_d = 1'b0;
					rel_cnt_d   = 32'h0000_0000; // RULE19
					abs_cnt_d   = 32'h0000_0000;
					pre_vld_d   = 1'b0;
				end
			end
			ST_RUN: begin
				if (stop_w) begin
					state_d = ST_IDLE;
				end else if (start_w) begin
					term_d      = reg_wdata_i[trace_qual_pkg::CTL_INIT +: 3]; // RULE19
					trig_seen_d = 1'b0;
					rel_cnt_d   = 32'h0000_0000;
					abs_cnt_d   = 32'h0000_0000;
					pre_vld_d   = 1'b0;
				end else if (take) begin
					term_d = sq.next_term;
					if (sq.advance && !trig_seen_q &&
						term_q == ctrl_q[trace_qual_pkg::CTL_TRIG +: 3]) begin
						trig_seen_d = 1'b1;
						trig_d      = 1'b1;
						abs_cnt_d   = 32'h0000_0000; // RULE13
					end
					if (store_now) begin
						store_d   = 1'b1;
						sdata_d   = smp_data_i;
						sterm_d   = term_q;
						sadv_d    = sq.advance;
						scnt_d    = (cmode_eff == trace_qual_pkg::CM_NONE) ?
							32'h0000_0000 : ctrl_q[trace_qual_pkg::CTL_ABS] ?
							abs_cnt_q : rel_cnt_q; // RULE13
						rel_cnt_d = cnt_inc ? 32'h0000_0001 : 32'h0000_0000;
						pre_d     = pre_vld_q; // RULE11
						pdata_d   = pre_buf_q;
						pre_vld_d = 1'b0;
					end else if (trace_qual_pkg::qual_eval(preq_q,
						pat_hit_i)) begin
						pre_vld_d = 1'b1; // RULE11
						pre_buf_d = smp_data_i;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q     <= ST_IDLE;
			term_q      <= 3'h0;
			trig_seen_q <= 1'b0;
			rel_cnt_q   <= 32'h0000_0000;
			abs_cnt_q   <= 32'h0000_0000;
			pre_vld_q   <= 1'b0;
			pre_buf_q   <= 32'h0000_0000;
			store_q     <= 1'b0;
			sdata_q     <= 32'h0000_0000;
			sterm_q     <= 3'h0;
			sadv_q      <= 1'b0;
			scnt_q      <= 32'h0000_0000;
			pre_q       <= 1'b0;
			pdata_q     <= 32'h0000_0000;
			trig_q      <= 1'b0;
		end else if (ce_i) begin
			state_q     <= state_d;
			term_q      <= term_d;
			trig_seen_q <= trig_seen_d;
			rel_cnt_q   <= rel_cnt_d;
			abs_cnt_q   <= abs_cnt_d;
			pre_vld_q   <= pre_vld_d;
			pre_buf_q   <= pre_buf_d;
			store_q     <= store_d;
			sdata_q     <= sdata_d;
			sterm_q     <= sterm_d;
			sadv_q      <= sadv_d;
			scnt_q      <= scnt_d;
			pre_q       <= pre_d;
			pdata_q     <= pdata_d;
			trig_q      <= trig_d;
		end
	end

	assign reg_rdata_o     = rdata_q;
	assign ana_clk_en_o    = trace_qual_pkg::CLK_LINE_SEL; // RULE15
	assign wait_insert_o   = wait_ins; // RULE9
	assign store_o         = store_q;
	assign store_data_o    = sdata_q;
	assign store_term_o    = sterm_q;
	assign store_seq_adv_o = sadv_q;
	assign store_count_o   = scnt_q;
	assign pre_o           = pre_q;
	assign pre_data_o      = pdata_q;
	assign trig_o          = trig_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_adv_sample;
		ce_i && take && sq.advance && !start_w && !stop_w;
	endsequence

	sequence s_start;
		ce_i && start_w && !stop_w;
	endsequence

	a_adv_store_incl: assert property ( // RULE1
		s_adv_sample ##0 ctrl_q[trace_qual_pkg::CTL_INC]
		|=> store_o && store_seq_adv_o)
		else $error("advance state not stored");
	a_adv_store_excl: assert property ( // RULE2
		s_adv_sample ##0 !ctrl_q[trace_qual_pkg::CTL_INC] && !sq.store_hit
		|=> !store_o)
		else $error("unqualified advance state stored");
	a_start_init_term: assert property ( // RULE3
		s_start |=> running && term_q == $past(reg_wdata_i[3:1]))
		else $error("initial term not loaded at start");
	a_start_clear_cnt: assert property ( // RULE19
		s_start |=> rel_cnt_q == 32'h0 && abs_cnt_q == 32'h0)
		else $error("counters not cleared at start");
	a_ctx_reject: assert property ( // RULE4
		ce_i && smp_valid_i && !ctx_ok && !start_w
		|=> !store_o && term_q == $past(term_q))
		else $error("out of context state used");
	a_reset_defaults: assert property ( // RULE6
		$rose(rst_b_i) |-> rate_cls == trace_qual_pkg::RATE_VFAST
		&& cntq_q == trace_qual_pkg::QUAL_NEVER)
		else $error("reset defaults wrong");
	a_count_limit: assert property ( // RULE10
		rate_cls == trace_qual_pkg::RATE_VFAST && ce_i && running
		|=> rel_cnt_q == $past(rel_cnt_q) || $past(store_now) || $past(start_w))
		else $error("counting at very fast rate");
	a_wait_state: assert property ( // RULE9
		busclk_q >= 8'h19 |-> wait_insert_o && eff_mhz == {1'b0, busclk_q[7:1]})
		else $error("wait state not inserted");
	a_clk_line_one: assert property ( // RULE15
		$onehot(ana_clk_en_o))
		else $error("analysis clock lines not one-hot");
	a_last_term_hold: assert property ( // RULE17
		ce_i && take && !stop_w && !start_w && term_q == 3'h7 && sq.prim_hit
		&& !term_b_q[7][19] |=> term_q == 3'h7)
		else $error("last term left on default branch");
	a_prim_wins: assert property ( // RULE18
		ce_i && take && !stop_w && !start_w && sq.prim_hit && sq.sec_hit
		|=> term_q == trace_qual_pkg::branch_dest($past(sq.word_b[19:16]),
			$past(term_q)))
		else $error("secondary branch taken over primary");
	a_prestore_out: assert property ( // RULE11
		ce_i && store_now && !start_w && !stop_w && pre_vld_q
		|=> pre_o && pre_data_o == $past(pre_buf_q))
		else $error("prestore state lost");
endmodule

//--- bus_trace_capture_qualifier_bench.sv
// Self-checking bench of the trace capture qualifier
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %0h exp %0h", $time, a, e); end end

module bus_trace_capture_qualifier_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [1:0] capture_both_contexts = 2'h3;
	localparam logic [1:0] rate_class_very_fast  = 2'h2;

	logic        clk;
	logic        rst_b_i;
	logic [6:0]  reg_addr_i;
	logic [31:0] reg_wdata_i;
	logic        reg_we_i;
	logic        reg_re_i;
	logic [31:0] reg_rdata_o;
	logic        smp_valid;
	logic [31:0] smp_data;
	logic        smp_bg;
	logic [7:0]  pat_hit;
	logic [4:0]  ana_clk_en_o;
	logic        wait_insert_o;
	logic        store_o;
	logic [31:0] store_data_o;
	logic [2:0]  store_term_o;
	logic        store_seq_adv_o;
	logic [31:0] store_count_o;
	logic        pre_o;
	logic [31:0] pre_data_o;
	logic        trig_o;
	int          checks;
	int          miscompares;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	bus_state_source src (
		.clk_i       (clk),
		.smp_valid_o (smp_valid),
		.smp_data_o  (smp_data),
		.smp_bg_o    (smp_bg),
		.pat_hit_o   (pat_hit)
	);

	bus_trace_capture_qualifier dut (
		.clk_i           (clk),
		.rst_b_i         (rst_b_i),
		.ce_i            (1'b1),
		.reg_addr_i      (reg_addr_i),
		.reg_wdata_i     (reg_wdata_i),
		.reg_we_i        (reg_we_i),
		.reg_re_i        (reg_re_i),
		.reg_rdata_o     (reg_rdata_o),
		.smp_valid_i     (smp_valid),
		.smp_data_i      (smp_data),
		.smp_bg_i        (smp_bg),
		.pat_hit_i       (pat_hit),
		.ana_clk_en_o    (ana_clk_en_o),
		.wait_insert_o   (wait_insert_o),
		.store_o         (store_o),
		.store_data_o    (store_data_o),
		.store_term_o    (store_term_o),
		.store_seq_adv_o (store_seq_adv_o),
		.store_count_o   (store_count_o),
		.pre_o           (pre_o),
		.pre_data_o      (pre_data_o),
		.trig_o          (trig_o)
	);

	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_we_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk);
		reg_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_re_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk);
		reg_re_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	// Writes the control word with the start bit set
	task automatic start(input logic inc, input logic [2:0] init,
			input logic [1:0] ctx, input logic [1:0] rate,
			input logic [1:0] mode, input logic cplx);
		wr(trace_qual_pkg::REG_CTRL, {16'h0000, 1'b1, 3'h0, cplx, 1'b0,
			mode, rate, ctx, init, inc});
	endtask

	// Store pulse stands in the cycle after the sample edge
	task automatic smp(input logic [31:0] d, input logic bg,
			input logic [7:0] h, input logic exp);
		src.send(d, bg, h);
		#1 `CHK(store_o, exp)
	endtask

	task automatic status(input logic [2:0] term);
		logic [31:0] v;
		rd(trace_qual_pkg::REG_STATUS, v);
		`CHK(v[3:1], term)
	endtask

	task automatic t_reset();
		logic [31:0] v;
		rd(trace_qual_pkg::REG_CTRL, v);
		`CHK(v[0], 1'b1)
		`CHK(v[7:6], rate_class_very_fast)
		rd(trace_qual_pkg::REG_CNTQ, v);
		`CHK(v, 32'h0000_0000)
		`CHK(ana_clk_en_o, 5'h04)
		`CHK(wait_insert_o, 1'b1)
		rd(7'h7C, v);
		`CHK(v, 32'h0000_0000)
		rd(7'h02, v);
		`CHK(v, 32'h0000_0000)
		$display("test reset done");
	endtask

	task automatic t_seqadv();
		wr(trace_qual_pkg::REG_TERM0, 32'h0001_0000);
		start(1'b1, 3'h0, 2'h1, 2'h2, 2'h0, 1'b0);
		smp(32'hA5A5_0001, 1'b0, 8'h01, 1'b1);
		`CHK(store_seq_adv_o, 1'b1)
		`CHK(store_term_o, 3'h0)
		`CHK(store_data_o, 32'hA5A5_0001)
		status(3'h1);
		start(1'b0, 3'h0, 2'h1, 2'h2, 2'h0, 1'b0);
		smp(32'hA5A5_0002, 1'b0, 8'h01, 1'b0);
		status(3'h1);
		start(1'b1, 3'h0, 2'h1, 2'h2, 2'h0, 1'b0);
		smp(32'hA5A5_0003, 1'b0, 8'h01, 1'b1);
		$display("test seq advance done");
	endtask

	task automatic t_init();
		wr(trace_qual_pkg::REG_TERM0 + 7'h28, 32'h0001_0000);
		wr(trace_qual_pkg::REG_TERM0 + 7'h38, 32'h0001_0000);
		start(1'b1, 3'h5, 2'h1, 2'h2, 2'h0, 1'b0);
		status(3'h5);
		smp(32'h0000_0055, 1'b0, 8'h01, 1'b1);
		`CHK(store_term_o, 3'h5)
		status(3'h6);
		start(1'b1, 3'h7, 2'h1, 2'h2, 2'h0, 1'b0);
		smp(32'h0000_0077, 1'b0, 8'h01, 1'b0);
		status(3'h7);
		$display("test initial term done");
	endtask

	task automatic t_ctx();
		wr(trace_qual_pkg::REG_TERM0, 32'h0000_0100);
		for (int c = 1; c <= int'(capture_both_contexts); c++) begin
			start(1'b1, 3'h0, 2'(c), 2'h2, 2'h0, 1'b0);
			smp(32'h0000_1000, 1'b0, 8'h00, c[0]);
			smp(32'h0000_2000, 1'b1, 8'h00, c[1]);
		end
		$display("test context done");
	endtask

	task automatic cnt_run(input logic [1:0] rate, input logic [1:0] mode,
			input logic [31:0] exp);
		start(1'b1, 3'h0, 2'h1, rate, mode, 1'b0);
		repeat (3) smp(32'h0000_0000, 1'b0, 8'h02, 1'b0);
		smp(32'h0000_00C0, 1'b0, 8'h01, 1'b1);
		`CHK(store_count_o, exp)
	endtask

	task automatic t_count();
		logic [31:0] v;
		wr(trace_qual_pkg::REG_TERM0, 32'h0000_0001);
		cnt_run(2'h0, 2'h2, 32'h0000_0000);
		wr(trace_qual_pkg::REG_CNTQ, 32'h0000_0002);
		cnt_run(2'h0, 2'h2, 32'h0000_0003);
		cnt_run(2'h1, 2'h2, 32'h0000_0003);
		cnt_run(2'h2, 2'h2, 32'h0000_0000);
		cnt_run(2'h1, 2'h1, 32'h0000_0000);
		rd(trace_qual_pkg::REG_STATUS, v);
		`CHK(v[10], 1'b1)
		$display("test count done");
	endtask

	// Slow class time counts, absolute to the trigger leaving term 0
	task automatic t_abs();
		wr(trace_qual_pkg::REG_TERM0, 32'h0002_0001);
		wr(trace_qual_pkg::REG_CTRL, 32'h0000_8511);
		smp(32'h0000_0AB1, 1'b0, 8'h02, 1'b1);
		`CHK(trig_o, 1'b1)
		`CHK(store_count_o, 32'h0000_0001)
		smp(32'h0000_0AB2, 1'b0, 8'h01, 1'b1);
		`CHK(trig_o, 1'b0)
		`CHK(store_count_o, 32'h0000_0001)
		$display("test absolute count done");
	endtask

	task automatic t_pre();
		wr(trace_qual_pkg::REG_PREQ, 32'h0000_0004);
		start(1'b1, 3'h0, 2'h1, 2'h2, 2'h0, 1'b0);
		smp(32'h1111_2222, 1'b0, 8'h04, 1'b0);
		smp(32'h3333_4444, 1'b0, 8'h01, 1'b1);
		`CHK(pre_o, 1'b1)
		`CHK(pre_data_o, 32'h1111_2222)
		smp(32'h5555_6666, 1'b0, 8'h01, 1'b1);
		`CHK(pre_o, 1'b0)
		$display("test prestore done");
	endtask

	// Expected status bits: bus clock within 40, wait inserted, rate class
	task automatic t_clk();
		logic [7:0]  mhz [5] = '{8'h18, 8'h19, 8'h20, 8'h28, 8'h2A};
		logic [3:0]  st [5] = '{4'hA, 4'hC, 4'hC, 4'hD, 4'h6};
		logic [31:0] v;
		for (int i = 0; i < 5; i++) begin
			wr(trace_qual_pkg::REG_BUSCLK, {24'h0, mhz[i]});
			rd(trace_qual_pkg::REG_STATUS, v);
			`CHK(v[7:6], st[i][1:0])
			`CHK(v[8], st[i][2])
			`CHK(wait_insert_o, st[i][2])
			`CHK(v[9], st[i][3])
		end
		wr(trace_qual_pkg::REG_BUSCLK, 32'h0000_0028);
		$display("test bus clock done");
	endtask

	task automatic t_prim();
		wr(trace_qual_pkg::REG_TERM0, 32'h0001_0000);
		wr(trace_qual_pkg::REG_TERM0 + 7'h04, 32'h00DB_0001);
		start(1'b1, 3'h0, 2'h1, 2'h2, 2'h0, 1'b1);
		smp(32'h0000_0E01, 1'b0, 8'h01, 1'b1);
		status(3'h3);
		smp(32'h0000_0E02, 1'b0, 8'h00, 1'b1);
		`CHK(store_term_o, 3'h3)
		start(1'b1, 3'h3, 2'h1, 2'h2, 2'h0, 1'b0);
		smp(32'h0000_0E03, 1'b0, 8'h00, 1'b0);
		$display("test branch priority done");
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("[ERR] %0t run limit reached", $time);
		print_verdict();
	end

	initial begin
		checks      = 0;
		miscompares = 0;
		rst_b_i     = 1'b0;
		reg_addr_i  = 7'h00;
		reg_wdata_i = 32'h0000_0000;
		reg_we_i    = 1'b0;
		reg_re_i    = 1'b0;
		repeat (5) @(posedge clk);
		rst_b_i <= 1'b1;
		t_reset();
		t_seqadv();
		t_init();
		t_ctx();
		t_count();
		t_abs();
		t_pre();
		t_clk();
		t_prim();
		print_verdict();
	end
endmodule

//--- seq_if.sv
// Signals between the capture core and the sequencer step logic
interface seq_if;
	logic [trace_qual_pkg::PAT_W-1:0]  hits;
	logic [trace_qual_pkg::TERM_W-1:0] term;
	logic [trace_qual_pkg::DATA_W-1:0] word_a;
	logic [trace_qual_pkg::DATA_W-1:0] word_b;
	logic [trace_qual_pkg::DATA_W-1:0] word_a0;
	logic                              complex_cfg;
	logic [trace_qual_pkg::TERM_W-1:0] next_term;
	logic                              prim_hit;
	logic                              sec_hit;
	logic                              advance;
	logic                              store_hit;

	modport core (output hits, term, word_a, word_b, word_a0, complex_cfg,
		input next_term, prim_hit, sec_hit, advance, store_hit);
	modport step (input hits, term, word_a, word_b, word_a0, complex_cfg,
		output next_term, prim_hit, sec_hit, advance, store_hit);
endinterface

//--- seq_step.sv
// Combinational next-term and store decision of the trace sequencer
module seq_step (
	seq_if.step s
);
	logic [trace_qual_pkg::TERM_W-1:0] dest;

	always_comb begin
		s.prim_hit = trace_qual_pkg::qual_eval(
			s.word_a[trace_qual_pkg::QA_PRIM +: trace_qual_pkg::QUAL_W], s.hits);
		s.sec_hit = trace_qual_pkg::qual_eval(
			s.word_b[trace_qual_pkg::QB_SEC +: trace_qual_pkg::QUAL_W], s.hits);
		dest = s.term;
		if (s.prim_hit) begin
			dest = trace_qual_pkg::branch_dest( // RULE17
				s.word_b[trace_qual_pkg::QB_PTGT +: 4], s.term); // RULE18
		end else if (s.sec_hit) begin
			dest = trace_qual_pkg::branch_dest(
				s.word_b[trace_qual_pkg::QB_STGT +: 4], s.term);
		end
		s.next_term = dest;
		s.advance = (dest != s.term);
		// Easy configuration shares term one's store qualifier globally
		if (s.complex_cfg) begin
			s.store_hit = trace_qual_pkg::qual_eval( // RULE16
				s.word_a[trace_qual_pkg::QA_STORE +: trace_qual_pkg::QUAL_W],
				s.hits);
		end else begin
			s.store_hit = trace_qual_pkg::qual_eval(
				s.word_a0[trace_qual_pkg::QA_STORE +: trace_qual_pkg::QUAL_W],
				s.hits);
		end
	end
endmodule

//--- trace_qual_pkg.sv
// Constants, register map and shared helpers of the trace capture qualifier
// How it works
// RULE1 - By default every state that advances the sequencer is stored.
// RULE2 - Clearing the inclusion bit keeps advance states only when qualified.
// RULE3 - A programmable initial term becomes active when a trace starts.
// RULE4 - Capture context selects user states, background states, or both.
// RULE5 - Rate classes: slow up to 16 MHz, fast up to 20, very fast above.
// RULE6 - After reset the rate class is very fast.
// RULE7 - Every bus cycle is captured up to a 40 MHz processor clock.
// RULE8 - Burst sample rate is bus clock over one plus wait states.
// RULE9 - One wait state is inserted when the bus clock is 25 MHz or more.
// RULE10 - Slow allows time or state counts, fast state only, very fast none.
// RULE11 - Prestore keeps a qualified state preceding a stored state.
// RULE12 - Count qualifier records time, matching states, or nothing.
// RULE13 - Counts are given relative to the last store or to the trigger.
// RULE14 - After reset the count qualifier never matches.
// RULE15 - Exactly one of five analysis clock lines clocks the analyzer.
// RULE16 - Complex mode gives each of eight terms its own store qualifier.
// RULE17 - A branch without target goes one term up; term eight stays.
// RULE18 - When both branches match, the primary branch is taken.
// RULE19 - Trace start clears counters and loads the initial term first.
package trace_qual_pkg;
	localparam int ADDR_W  = 7;
	localparam int DATA_W  = 32;
	localparam int STATE_W = 32;
	localparam int N_TERMS = 8;
	localparam int TERM_W  = 3;
	localparam int PAT_W   = 8;
	localparam int QUAL_W  = 9;
	localparam int CLK_LINES = 5;

	localparam logic [ADDR_W-1:0] REG_CTRL   = 7'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 7'h04;
	localparam logic [ADDR_W-1:0] REG_PREQ   = 7'h08;
	localparam logic [ADDR_W-1:0] REG_CNTQ   = 7'h0C;
	localparam logic [ADDR_W-1:0] REG_BUSCLK = 7'h10;
	localparam logic [ADDR_W-1:0] REG_TERM0  = 7'h20;
	localparam logic [ADDR_W-1:0] REG_TERM_END = 7'h60;

	localparam int CTL_INC   = 0;
	localparam int CTL_INIT  = 1;
	localparam int CTL_CTX   = 4;
	localparam int CTL_RATE  = 6;
	localparam int CTL_CMODE = 8;
	localparam int CTL_ABS   = 10;
	localparam int CTL_CPLX  = 11;
	localparam int CTL_TRIG  = 12;
	localparam int CTL_START = 15;
	localparam int CTL_STOP  = 16;
	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0091;
	localparam logic [DATA_W-1:0] CTRL_WMASK = 32'h0000_7FFF;

	localparam int QA_STORE = 0;
	localparam int QA_PRIM  = 16;
	localparam int QB_SEC   = 0;
	localparam int QB_PTGT  = 16;
	localparam int QB_STGT  = 20;
	localparam logic [DATA_W-1:0] TERMA_RST = 32'h0000_0100;
	localparam logic [DATA_W-1:0] TERMB_RST = 32'h0000_0000;
	localparam logic [QUAL_W-1:0] QUAL_NEVER = 9'h000;

	localparam logic [1:0] RATE_SLOW  = 2'h0;
	localparam logic [1:0] RATE_FAST  = 2'h1;
	localparam logic [1:0] RATE_VFAST = 2'h2;
	localparam logic [1:0] CM_NONE  = 2'h0;
	localparam logic [1:0] CM_TIME  = 2'h1;
	localparam logic [1:0] CM_STATE = 2'h2;

	localparam logic [7:0] SLOW_MAX_MHZ    = 8'h10;
	localparam logic [7:0] FAST_MAX_MHZ    = 8'h14;
	localparam logic [7:0] CAPTURE_MAX_MHZ = 8'h28;
	localparam logic [7:0] WAIT_MIN_MHZ    = 8'h19;
	localparam logic [7:0] BUSCLK_RST      = 8'h28;
	localparam logic [CLK_LINES-1:0] CLK_LINE_SEL = 5'h04;

	// Mask of pattern hits; bit 8 selects AND of selected, else OR
	function automatic logic qual_eval(input logic [QUAL_W-1:0] q,
			input logic [PAT_W-1:0] hits);
		if (q[QUAL_W-1])
			return &(hits | ~q[PAT_W-1:0]);
		return |(hits & q[PAT_W-1:0]);
	endfunction

	// Target field: bit 3 set names a term, else next higher, last stays
	function automatic logic [TERM_W-1:0] branch_dest(input logic [3:0] tgt,
			input logic [TERM_W-1:0] cur);
		if (tgt[3])
			return tgt[2:0];
		if (cur == 3'(N_TERMS - 1))
			return cur;
		return 3'(cur + 3'h1);
	endfunction

	function automatic logic [1:0] count_allowed(input logic [1:0] mode,
			input logic [1:0] rate);
		case (rate)
			RATE_SLOW: return mode;
			RATE_FAST: return (mode == CM_STATE) ? CM_STATE : CM_NONE;
			default:   return CM_NONE;
		endcase
	endfunction
endpackage
